/* edge_glitch_trigger_detector.sv */
// edge and glitch trigger detector with holdoff and a wishbone register file
`timescale 1ns/10ps
`include "trig_regs.svh"

// Function
// [RL1] edge mode: direction qualified, fires at level crossing
// [RL2] edge source: four channels, aux or line
// [RL3] direction rising, falling or either, per source
// [RL4] line source ignores direction and level
// [RL5] one level per channel shared by modes
// [RL6] direction read returns code of current source
// [RL7] selected source targets later direction accesses
// [RL8] glitch fires only below programmed width
// [RL9] positive glitch fires on ending falling crossing
// [RL10] negative glitch fires on ending rising crossing
// [RL11] glitch width limit 1.5 ns to 10 s
// [RL12] glitch source only the four channels
// [RL13] host selects edge mode before edge settings
// [RL14] host selects glitch mode before glitch settings
// [RL15] polarity read returns positive or negative code
// [RL16] both modes pass holdoff and hysteresis stages
// [RL17] holdoff after trigger, at most 10 s
// [RL18] crossing found by differing consecutive comparisons
module edge_glitch_trigger_detector
	import trig_pkg::*;
#(
	parameter logic [31:0] GL_WIDTH_MAX = 32'(`GL_WIDTH_MAX_CYC),
	parameter logic [31:0] HOLDOFF_MAX = 32'(`HOLDOFF_MAX_CYC)
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// digitized sources
	input wire logic [3:0][7:0] chan_sample_i,
	input wire logic [7:0] aux_sample_i,
	input wire logic line_ref_i,
	// trigger outputs
	output logic trig_o,
	output logic armed_o
);
	localparam logic [31:0] GL_WIDTH_MIN = 32'(`GL_WIDTH_MIN_CYC);
	localparam logic [31:0] HOLDOFF_MIN = 32'(`HOLDOFF_MIN_CYC);

	// bus state
	logic ack_r; // answer flag
	logic [31:0] dat_r; // read data
	logic [7:0] adr_w; // word aligned address
	logic wr_en; // write takes effect this edge
	// settings
	trig_mode_e mode_r; // trigger mode
	edge_src_e edge_src_r; // edge source
	logic [5:0][1:0] slope_tab_r; // direction per edge source
	logic gl_neg_r; // glitch polarity, high for negative
	logic [1:0] gl_src_r; // glitch channel
	logic [31:0] gl_width_r; // glitch width limit in cycles
	logic [31:0] holdoff_r; // holdoff in cycles
	logic hsens_r; // high sensitivity hysteresis
	logic [4:0][7:0] level_r; // one level per channel and aux
	// detection
	logic [4:0][7:0] samples; // all level sources
	xing_s xing [5]; // crossing results
	logic [7:0] hyst_amt; // hysteresis band
	logic line_q_r; // previous line reference
	logic line_rise; // line reference rising
	xing_s esel; // edge source crossing
	xing_s gsel; // glitch source crossing
	slope_e cur_slope; // direction of current edge source
	logic edge_evt; // edge condition met
	logic gl_start; // pulse begins
	logic gl_end; // pulse ends
	logic glitch_evt; // narrow pulse ended
	logic raw_evt; // candidate trigger
	glitch_st_e gl_st_r; // glitch state
	logic [31:0] pw_cnt_r; // pulse width counter
	logic gl_cfg_chg; // glitch polarity, source or mode written
	// holdoff and outputs
	logic [31:0] ho_cnt_r; // holdoff remaining
	logic armed_r; // trigger enabled
	logic trig_r; // trigger pulse
	logic [15:0] tcnt_r; // accepted triggers

	// byte lane merge for wide registers
	function automatic logic [31:0] bmerge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// limit a value to a range
	function automatic logic [31:0] clamp(input logic [31:0] v, input logic [31:0] lo,
		input logic [31:0] hi);
		return (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	assign adr_w = {wb_adr_i[7:2], 2'b00};
	// writes take effect on the edge at which the master sees ack
	assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;

	// ack one cycle after the request, dropped the cycle after
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
		end
	end

	// read data captured with the request; unmapped reads zero
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			dat_r <= 32'h00000000;
		end else if (wb_cyc_i && wb_stb_i && !ack_r) begin
			dat_r <= 32'h00000000;
			case (adr_w)
				`OFS_MODE: dat_r[1:0] <= mode_r;
				`OFS_EDGE_SRC: dat_r[2:0] <= edge_src_r; // RL2
				`OFS_EDGE_SLOPE: dat_r[1:0] <= slope_tab_r[edge_src_r]; // RL6
				`OFS_GL_POL: dat_r[0] <= gl_neg_r; // RL15
				`OFS_GL_SRC: dat_r[1:0] <= gl_src_r;
				`OFS_GL_WIDTH: dat_r <= gl_width_r;
				`OFS_HOLDOFF: dat_r <= holdoff_r;
				`OFS_HYST: dat_r[0] <= hsens_r;
				`OFS_STATUS: begin
					dat_r[`STAT_ARMED_BIT] <= armed_r;
					dat_r[`STAT_GL_BUSY_BIT] <= (gl_st_r != GL_IDLE);
					dat_r[`STAT_TCNT_LSB +: 16] <= tcnt_r;
				end
				default: begin
					if (adr_w >= `OFS_LEVEL0 && adr_w <= `OFS_LEVEL4) begin
						dat_r[7:0] <= level_r[3'(adr_w[7:2] - 6'h08)];
					end
				end
			endcase
		end
	end

	// mode, hysteresis and shared level registers
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			mode_r <= MODE_EDGE;
			hsens_r <= 1'b0;
			level_r <= {5{`RST_LEVEL}};
		end else if (wr_en && wb_sel_i[0]) begin
			if (adr_w == `OFS_MODE && wb_dat_i[1:0] <= MODE_GLITCH) begin
				mode_r <= trig_mode_e'(wb_dat_i[1:0]);
			end
			if (adr_w == `OFS_HYST) begin
				hsens_r <= wb_dat_i[0];
			end
			// a level write in any mode lands in the single per-channel copy
			if (adr_w >= `OFS_LEVEL0 && adr_w <= `OFS_LEVEL4) begin
				level_r[3'(adr_w[7:2] - 6'h08)] <= wb_dat_i[7:0]; // RL5
			end
		end
	end

	// edge settings, accepted only in edge mode
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			edge_src_r <= SRC_CH1;
			slope_tab_r <= '0;
		end else if (wr_en && wb_sel_i[0] && mode_r == MODE_EDGE) begin // RL13
			if (adr_w == `OFS_EDGE_SRC && wb_dat_i[2:0] <= SRC_LINE) begin
				edge_src_r <= edge_src_e'(wb_dat_i[2:0]); // RL2 RL7
			end
			// direction lands against the current source; line takes none
			if (adr_w == `OFS_EDGE_SLOPE && wb_dat_i[1:0] <= SLOPE_EITHER &&
				edge_src_r != SRC_LINE) begin
				slope_tab_r[edge_src_r] <= wb_dat_i[1:0]; // RL3 RL4 RL7
			end
		end
	end

	// glitch settings, accepted only in glitch mode
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			gl_neg_r <= 1'b0;
			gl_src_r <= 2'b00;
			gl_width_r <= `RST_GL_WIDTH;
		end else if (wr_en && mode_r == MODE_GLITCH) begin // RL14
			if (adr_w == `OFS_GL_POL && wb_sel_i[0]) begin
				gl_neg_r <= wb_dat_i[0];
			end
			// two bits leave only the four channels selectable
			if (adr_w == `OFS_GL_SRC && wb_sel_i[0]) begin
				gl_src_r <= wb_dat_i[1:0]; // RL12
			end
			if (adr_w == `OFS_GL_WIDTH) begin
				gl_width_r <= clamp(bmerge(gl_width_r, wb_dat_i, wb_sel_i),
					GL_WIDTH_MIN, GL_WIDTH_MAX); // RL11
			end
		end
	end

	// holdoff setting, clamped to its range
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			holdoff_r <= `RST_HOLDOFF;
		end else if (wr_en && adr_w == `OFS_HOLDOFF) begin
			holdoff_r <= clamp(bmerge(holdoff_r, wb_dat_i, wb_sel_i),
				HOLDOFF_MIN, HOLDOFF_MAX); // RL17
		end
	end

	// crossing detectors for the four channels and aux
	assign samples = {aux_sample_i, chan_sample_i};
	assign hyst_amt = hsens_r ? `HYST_HSENS : `HYST_NORMAL; // RL16
	for (genvar i = 0; i < 5; i++) begin : g_xing
		level_crossing u_xing (
			.ref_clk_i(ref_clk_i),
			.reset_n_i(reset_n_i),
			.sample_i(samples[i]),
			.level_i(level_r[i]),
			.hyst_i(hyst_amt),
			.xing_o(xing[i])
		);
	end

	// line reference edge, no level and no direction
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			line_q_r <= 1'b0;
		end else begin
			line_q_r <= line_ref_i;
		end
	end
	assign line_rise = line_ref_i & ~line_q_r; // RL4

	// edge condition: direction picks which crossing counts
	always_comb begin
		esel = (edge_src_r == SRC_LINE) ? '0 : xing[edge_src_r];
		cur_slope = slope_e'(slope_tab_r[edge_src_r]);
		case (cur_slope)
			SLOPE_POS: edge_evt = esel.rise; // RL1
			SLOPE_NEG: edge_evt = esel.fall; // RL1
			SLOPE_EITHER: edge_evt = esel.rise | esel.fall; // RL3
			default: edge_evt = 1'b0;
		endcase
		if (edge_src_r == SRC_LINE) begin
			edge_evt = line_rise; // RL4
		end
	end

	// glitch pulse begins and ends by polarity
	assign gsel = xing[gl_src_r];
	assign gl_start = gl_neg_r ? gsel.fall : gsel.rise;
	assign gl_end = gl_neg_r ? gsel.rise : gsel.fall; // RL9 RL10
	assign glitch_evt = (gl_st_r == GL_MEAS) && gl_end && (pw_cnt_r < gl_width_r); // RL8
	assign gl_cfg_chg = wr_en && (adr_w == `OFS_GL_POL || adr_w == `OFS_GL_SRC ||
		adr_w == `OFS_MODE);

	// glitch width measurement; a wide pulse parks until it ends
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			gl_st_r <= GL_IDLE;
			pw_cnt_r <= 32'h00000000;
		end else if (gl_cfg_chg) begin
			gl_st_r <= GL_IDLE;
			pw_cnt_r <= 32'h00000000;
		end else begin
			case (gl_st_r)
				GL_IDLE: begin
					if (gl_start) begin
						gl_st_r <= GL_MEAS;
						pw_cnt_r <= 32'h00000001;
					end
				end
				GL_MEAS: begin
					if (gl_end) begin
						gl_st_r <= GL_IDLE;
					end else if (pw_cnt_r + 32'h00000001 >= gl_width_r) begin
						gl_st_r <= GL_WIDE; // RL8
					end else begin
						pw_cnt_r <= pw_cnt_r + 32'h00000001;
					end
				end
				GL_WIDE: begin
					if (gl_end) begin
						gl_st_r <= GL_IDLE;
					end
				end
				default: gl_st_r <= GL_IDLE;
			endcase
		end
	end

	assign raw_evt = (mode_r == MODE_EDGE) ? edge_evt : glitch_evt;

	// holdoff: accepted trigger disables triggering for holdoff cycles
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ho_cnt_r <= 32'h00000000;
			armed_r <= 1'b1;
			trig_r <= 1'b0;
			tcnt_r <= 16'h0000;
		end else if (armed_r && raw_evt) begin
			ho_cnt_r <= holdoff_r; // RL16 RL17
			armed_r <= 1'b0;
			trig_r <= 1'b1;
			tcnt_r <= tcnt_r + 16'h0001;
		end else begin
			trig_r <= 1'b0;
			if (ho_cnt_r > 32'h00000001) begin
				ho_cnt_r <= ho_cnt_r - 32'h00000001; // RL17
			end else if (ho_cnt_r == 32'h00000001) begin
				ho_cnt_r <= 32'h00000000;
				armed_r <= 1'b1;
			end
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;
	assign trig_o = trig_r;
	assign armed_o = armed_r;

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);

	holdoff_gap_a: assert property ( // RL17
		trig_r |=> !trig_r [*8]) else $error("trigger repeated inside holdoff");
	edge_fire_a: assert property ( // RL1
		armed_r && mode_r == MODE_EDGE && edge_src_r != SRC_LINE &&
		cur_slope == SLOPE_POS && esel.rise |=> trig_r)
		else $error("rising crossing did not fire");
	line_fire_a: assert property ( // RL4
		armed_r && mode_r == MODE_EDGE && edge_src_r == SRC_LINE && line_rise |=> trig_r)
		else $error("line edge did not fire");
	trig_cause_a: assert property ( // RL16
		trig_r |-> $past(armed_r) && $past(raw_evt)) else $error("trigger without cause");
	glitch_narrow_a: assert property ( // RL8
		trig_r && $past(mode_r) == MODE_GLITCH |-> $past(pw_cnt_r < gl_width_r))
		else $error("glitch fired on wide pulse");
	glitch_pos_a: assert property ( // RL9
		trig_r && $past(mode_r) == MODE_GLITCH && !$past(gl_neg_r) |-> $past(gsel.fall))
		else $error("positive glitch not on falling crossing");
	glitch_neg_a: assert property ( // RL10
		trig_r && $past(mode_r) == MODE_GLITCH && $past(gl_neg_r) |-> $past(gsel.rise))
		else $error("negative glitch not on rising crossing");
	width_range_a: assert property ( // RL11
		gl_width_r >= GL_WIDTH_MIN && gl_width_r <= GL_WIDTH_MAX)
		else $error("glitch width out of range");
	src_stable_a: assert property ( // RL7
		$changed(edge_src_r) |-> $past(wr_en) && $past(adr_w) == `OFS_EDGE_SRC)
		else $error("edge source changed without write");
	slope_read_a: assert property ( // RL6
		wb_cyc_i && wb_stb_i && !ack_r && !wb_we_i && adr_w == `OFS_EDGE_SLOPE
		|=> ack_r && dat_r[1:0] == $past(slope_tab_r[edge_src_r]))
		else $error("direction readback wrong");
	level_write_a: assert property ( // RL5
		wr_en && wb_sel_i[0] && adr_w == `OFS_LEVEL0 |=> level_r[0] == $past(wb_dat_i[7:0]))
		else $error("shared level not written");

	edge_trig_c: cover property (mode_r == MODE_EDGE && trig_r);
	glitch_trig_c: cover property (mode_r == MODE_GLITCH && trig_r);
	wide_pulse_c: cover property (gl_st_r == GL_WIDE ##1 gl_st_r == GL_IDLE);
	rearm_c: cover property (trig_r ##[1:20] armed_r);
endmodule

/* trig_regs.svh */
// register offsets, reset values and timing counts of the trigger detector
`ifndef TRIG_REGS_SVH
`define TRIG_REGS_SVH

// register byte offsets
`define OFS_MODE 8'h00
`define OFS_EDGE_SRC 8'h04
`define OFS_EDGE_SLOPE 8'h08
`define OFS_GL_POL 8'h0C
`define OFS_GL_SRC 8'h10
`define OFS_GL_WIDTH 8'h14
`define OFS_HOLDOFF 8'h18
`define OFS_HYST 8'h1C
`define OFS_LEVEL0 8'h20
`define OFS_LEVEL4 8'h30
`define OFS_STATUS 8'h34

// field positions
`define STAT_ARMED_BIT 0
`define STAT_GL_BUSY_BIT 1
`define STAT_TCNT_LSB 16

// reset values
`define RST_LEVEL 8'h80
`define RST_GL_WIDTH 32'h00000064
`define RST_HOLDOFF 32'h0000000A

// hysteresis bands in sample codes
`define HYST_NORMAL 8'h04
`define HYST_HSENS 8'h01

// clock and timing figures
`define CLK_PERIOD_PS 64'd10000
`define PS_PER_NS 64'd1000
`define PS_PER_S 64'd1000000000000
`define GL_WIDTH_MIN_PS 64'd1500
`define GL_WIDTH_MAX_S 64'd10
`define HOLDOFF_MIN_NS 64'd100
`define HOLDOFF_MAX_S 64'd10
`define GL_WIDTH_MIN_CYC ((`GL_WIDTH_MIN_PS + `CLK_PERIOD_PS - 64'd1) / `CLK_PERIOD_PS)
`define GL_WIDTH_MAX_CYC (`GL_WIDTH_MAX_S * `PS_PER_S / `CLK_PERIOD_PS)
`define HOLDOFF_MIN_CYC ((`HOLDOFF_MIN_NS * `PS_PER_NS + `CLK_PERIOD_PS - 64'd1) / `CLK_PERIOD_PS)
`define HOLDOFF_MAX_CYC (`HOLDOFF_MAX_S * `PS_PER_S / `CLK_PERIOD_PS)

`endif

/* trig_pkg.sv */
// types shared by the trigger detector files
package trig_pkg;

	// trigger mode
	typedef enum logic [1:0] {
		MODE_EDGE = 2'b00,
		MODE_GLITCH = 2'b01
	} trig_mode_e;

	// edge source choice
	typedef enum logic [2:0] {
		SRC_CH1 = 3'b000,
		SRC_CH2 = 3'b001,
		SRC_CH3 = 3'b010,
		SRC_CH4 = 3'b011,
		SRC_AUX = 3'b100,
		SRC_LINE = 3'b101
	} edge_src_e;

	// edge direction codes, also the readback codes
	typedef enum logic [1:0] {
		SLOPE_POS = 2'b00,
		SLOPE_NEG = 2'b01,
		SLOPE_EITHER = 2'b10
	} slope_e;

	// glitch width measurement states
	typedef enum logic [1:0] {
		GL_IDLE = 2'b00,
		GL_MEAS = 2'b01,
		GL_WIDE = 2'b10
	} glitch_st_e;

	// level crossing result of one source
	typedef struct packed {
		logic above;
		logic rise;
		logic fall;
	} xing_s;

endpackage

/* level_crossing.sv */
// level crossing detector with hysteresis for one sampled source
`timescale 1ns/10ps
module level_crossing
	import trig_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	// sample and settings
	input wire logic [7:0] sample_i,
	input wire logic [7:0] level_i,
	input wire logic [7:0] hyst_i,
	// crossing result
	output xing_s xing_o
);
	logic above_r; // comparison state of the previous sample
	logic above_nxt; // comparison state of the current sample
	logic rise_r; // upward crossing pulse
	logic fall_r; // downward crossing pulse
	logic hi_hit; // sample at or above upper band edge
	logic lo_hit; // sample below lower band edge

	// band edges use nine bits so neither end wraps
	assign hi_hit = {1'b0, sample_i} >= ({1'b0, level_i} + {1'b0, hyst_i});
	assign lo_hit = ({1'b0, sample_i} + {1'b0, hyst_i}) < {1'b0, level_i};

	// inside the band the old state holds, which rejects noise
	always_comb begin
		if (hi_hit) begin
			above_nxt = 1'b1;
		end else if (lo_hit) begin
			above_nxt = 1'b0;
		end else begin
			above_nxt = above_r;
		end
	end

	// consecutive results that differ mark a crossing
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			above_r <= 1'b0;
			rise_r <= 1'b0;
			fall_r <= 1'b0;
		end else begin
			above_r <= above_nxt;
			rise_r <= above_nxt & ~above_r; // RL18
			fall_r <= ~above_nxt & above_r; // RL18
		end
	end

	assign xing_o = '{above: above_r, rise: rise_r, fall: fall_r};
endmodule

/* edge_glitch_trigger_detector_test.sv */
// self-checking testbench of the edge and glitch trigger detector
`timescale 1ns/10ps
`include "trig_regs.svh"
module edge_glitch_trigger_detector_test
	import trig_pkg::*;
;
	// clock, reset and bus signals
	logic ref_clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 32'h00000000;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	// source samples, index 4 is the aux input
	logic [4:0][7:0] samp = '0;
	logic line_ref_i = 1'b0;
	logic trig_o;
	logic armed_o;
	// bench bookkeeping
	logic [3:0] bus_sel = 4'hF;
	logic [31:0] trig_cnt = 32'h00000000;
	logic [31:0] n0;
	logic [31:0] rd;
	int failures = 0;
	int checks = 0;

	// small limits keep clamp tests short
	edge_glitch_trigger_detector #(.GL_WIDTH_MAX(32'd2000), .HOLDOFF_MAX(32'd2000)) i_dut (
		.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.chan_sample_i(samp[3:0]), .aux_sample_i(samp[4]), .line_ref_i(line_ref_i),
		.trig_o(trig_o), .armed_o(armed_o));

	// 100 MHz clock
	always #5 ref_clk_i = ~ref_clk_i;

	// counts accepted trigger pulses
	always @(posedge ref_clk_i) begin
		if (trig_o === 1'b1) trig_cnt <= trig_cnt + 32'd1;
	end

	// compares one value and reports a mismatch
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// one classic wishbone cycle, held until ack is sampled high
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
		int n;
		@(posedge ref_clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= bus_sel;
		wb_dat_i <= wd;
		n = 0;
		do begin
			@(posedge ref_clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 100);
		check("bus ack", {31'h0, wb_ack_o}, 32'h1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	// register write and checked read
	task automatic wr(input logic [7:0] adr, input logic [31:0] d);
		wb(1'b1, adr, d);
	endtask
	task automatic rdc(input string name, input logic [7:0] adr, input logic [31:0] exp);
		wb(1'b0, adr, 32'h0);
		check(name, rd, exp);
	endtask

	// moves one source to a new value and lets the trigger path settle
	task automatic drive(input int ch, input logic [7:0] v);
		@(posedge ref_clk_i);
		samp[ch] <= v;
		repeat (30) @(posedge ref_clk_i);
	endtask

	// pulse of k cycles away from the base value, then settle
	task automatic pulse(input int ch, input logic [7:0] v, input logic [7:0] base, input int k);
		@(posedge ref_clk_i);
		samp[ch] <= v;
		repeat (k) @(posedge ref_clk_i);
		samp[ch] <= base;
		repeat (30) @(posedge ref_clk_i);
	endtask

	// checks the number of triggers since n0
	task automatic fired(input string name, input logic [31:0] exp);
		check(name, trig_cnt - n0, exp);
		n0 = trig_cnt;
	endtask

	// prints counts and verdict, ends the run
	task automatic give_verdict();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// watchdog cuts a hung run short
	initial begin
		#500000;
		failures++;
		give_verdict();
	end

	// main test sequence
	initial begin
		repeat (16) @(posedge ref_clk_i);
		reset_n_i <= 1'b1;
		// reset values and unmapped place
		rdc("mode", `OFS_MODE, 32'h0);
		rdc("edge source", `OFS_EDGE_SRC, 32'h0);
		rdc("direction", `OFS_EDGE_SLOPE, 32'h0);
		rdc("polarity", `OFS_GL_POL, 32'h0);
		rdc("glitch source", `OFS_GL_SRC, 32'h0);
		rdc("width", `OFS_GL_WIDTH, `RST_GL_WIDTH);
		rdc("holdoff", `OFS_HOLDOFF, `RST_HOLDOFF);
		rdc("hysteresis", `OFS_HYST, 32'h0);
		for (int i = 0; i < 5; i++) rdc("level", `OFS_LEVEL0 + 8'(4 * i), 32'h80);
		rdc("status armed", `OFS_STATUS, 32'h1);
		wr(8'h38, 32'hFFFFFFFF);
		rdc("unmapped", 8'h38, 32'h0);
		$display("test reset done");
		// edge directions on channel 1, level 0x80
		n0 = trig_cnt;
		for (int i = 0; i < 3; i++) begin
			wr(`OFS_EDGE_SLOPE, 32'(i));
			drive(0, 8'hFF);
			fired("rise fire", 32'(i != 1));
			drive(0, 8'h00);
			fired("fall fire", 32'(i != 0));
		end
		// hysteresis band of 4 codes, then 1 code
		wr(`OFS_EDGE_SLOPE, 32'h0);
		drive(0, 8'h82);
		fired("inside band", 32'h0);
		drive(0, 8'h84);
		fired("band edge", 32'h1);
		drive(0, 8'h00);
		wr(`OFS_HYST, 32'h1);
		drive(0, 8'h81);
		fired("high sens", 32'h1);
		drive(0, 8'h00);
		wr(`OFS_HYST, 32'h0);
		$display("test edge done");
		// holdoff drops an event that comes too soon
		wr(`OFS_HOLDOFF, 32'd40);
		wr(`OFS_EDGE_SLOPE, 32'h2);
		n0 = trig_cnt;
		pulse(0, 8'hFF, 8'h00, 6);
		check("armed in holdoff", {31'h0, armed_o}, 32'h0);
		repeat (40) @(posedge ref_clk_i);
		check("armed again", {31'h0, armed_o}, 32'h1);
		fired("holdoff drop", 32'h1);
		wr(`OFS_HOLDOFF, 32'd3);
		rdc("holdoff min", `OFS_HOLDOFF, 32'd10);
		wr(`OFS_HOLDOFF, 32'd2001);
		rdc("holdoff max", `OFS_HOLDOFF, 32'd2000);
		wr(`OFS_HOLDOFF, 32'd10);
		$display("test holdoff done");
		// direction stored per source, line has none
		for (int s = 0; s < 5; s++) begin
			wr(`OFS_EDGE_SRC, 32'(s));
			wr(`OFS_EDGE_SLOPE, 32'(s % 3));
		end
		for (int s = 0; s < 6; s++) begin
			wr(`OFS_EDGE_SRC, 32'(s));
			rdc("source", `OFS_EDGE_SRC, 32'(s));
			rdc("source dir", `OFS_EDGE_SLOPE, (s == 5) ? 32'h0 : 32'(s % 3));
		end
		wr(`OFS_EDGE_SLOPE, 32'h1);
		rdc("line dir", `OFS_EDGE_SLOPE, 32'h0);
		wr(`OFS_EDGE_SRC, 32'h7);
		rdc("bad source", `OFS_EDGE_SRC, 32'h5);
		// line fires on its own edge, channel moves ignored
		n0 = trig_cnt;
		drive(0, 8'hFF);
		@(posedge ref_clk_i);
		line_ref_i <= 1'b1;
		drive(0, 8'h00);
		line_ref_i <= 1'b0;
		fired("line", 32'h1);
		// aux keeps its stored falling direction
		wr(`OFS_EDGE_SRC, 32'h4);
		wr(`OFS_LEVEL4, 32'h40);
		drive(4, 8'hFF);
		fired("aux rise", 32'h0);
		drive(4, 8'h00);
		fired("aux fall", 32'h1);
		$display("test sources done");
		// level written in edge mode drives glitch mode
		wr(`OFS_LEVEL0 + 8'h08, 32'h40);
		wr(`OFS_GL_WIDTH, 32'd5);
		rdc("width edge mode", `OFS_GL_WIDTH, `RST_GL_WIDTH);
		wr(`OFS_MODE, 32'h1);
		wr(`OFS_EDGE_SRC, 32'h1);
		rdc("source glitch mode", `OFS_EDGE_SRC, 32'h4);
		rdc("shared level", `OFS_LEVEL0 + 8'h08, 32'h40);
		wr(`OFS_GL_SRC, 32'h2);
		rdc("glitch source", `OFS_GL_SRC, 32'h2);
		wr(`OFS_GL_WIDTH, 32'd8);
		n0 = trig_cnt;
		pulse(2, 8'h50, 8'h00, 7);
		fired("pos narrow", 32'h1);
		pulse(2, 8'h50, 8'h00, 8);
		fired("pos at width", 32'h0);
		pulse(2, 8'h50, 8'h00, 1);
		fired("pos one cycle", 32'h1);
		pulse(0, 8'hFF, 8'h00, 3);
		fired("other channel", 32'h0);
		// a level written in glitch mode lands in the shared copy
		wr(`OFS_LEVEL0, 32'h90);
		rdc("level glitch mode", `OFS_LEVEL0, 32'h90);
		wr(`OFS_GL_POL, 32'h1);
		rdc("polarity", `OFS_GL_POL, 32'h1);
		drive(2, 8'h50);
		n0 = trig_cnt;
		pulse(2, 8'h00, 8'h50, 7);
		fired("neg narrow", 32'h1);
		pulse(2, 8'h00, 8'h50, 8);
		fired("neg at width", 32'h0);
		// width limits and byte enables
		wr(`OFS_GL_WIDTH, 32'd0);
		rdc("width min", `OFS_GL_WIDTH, 32'd1);
		wr(`OFS_GL_WIDTH, 32'd5000);
		rdc("width max", `OFS_GL_WIDTH, 32'd2000);
		bus_sel = 4'h1;
		wr(`OFS_GL_WIDTH, 32'hFFFFFF08);
		bus_sel = 4'hF;
		rdc("width low byte", `OFS_GL_WIDTH, 32'h708);
		$display("test glitch done");
		// status count agrees with seen triggers
		wb(1'b0, `OFS_STATUS, 32'h0);
		check("status count", rd, {trig_cnt[15:0], 16'h0001});
		$display("test status done");
		give_verdict();
	end
endmodule
